// [core/hlt_pkg.sv]
`default_nettype none
package hlt_pkg;
    // ************************************************************
    // Register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [4:0] HLT_OFF_CLOCK_SELECT = 5'h00;
    localparam logic [4:0] HLT_OFF_CONTROL      = 5'h04;
    localparam logic [4:0] HLT_OFF_HW_LIMIT     = 5'h08;
    localparam logic [4:0] HLT_OFF_EXT_RESET    = 5'h0c;
    localparam logic [4:0] HLT_OFF_COUNT        = 5'h10;
    localparam logic [4:0] HLT_OFF_PERIOD       = 5'h14;
    localparam logic [4:0] HLT_OFF_SLEEP_CTRL   = 5'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int HLT_ON_BIT         = 7;
    localparam int HLT_PRESCALER_SYNC_EN_BIT      = 7;
    localparam int HLT_EDGE_BIT       = 6;
    localparam int HLT_ESYNC_BIT      = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] HLT_RST_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] HLT_RST_CONTROL      = 8'h00;
    localparam logic [7:0] HLT_RST_HW_LIMIT     = 8'h00;
    localparam logic [7:0] HLT_RST_EXT_RESET    = 8'h00;
    localparam logic [7:0] HLT_RST_COUNT        = 8'h00;
    localparam logic [7:0] HLT_RST_PERIOD       = 8'hff;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [3:0] HLT_CS_LAST_VALID  = 4'hc;
    localparam logic [3:0] HLT_RS_LAST_VALID  = 4'he;
    localparam logic [3:0] HLT_RS_FIRST_POST  = 4'h1;
    localparam logic [3:0] HLT_RS_SECOND_POST = 4'h2;
    localparam logic [4:0] HLT_MODE_ONE_SHOT  = 5'h08;
    localparam int         HLT_ENABLE_DELAY   = 2;
endpackage : hlt_pkg
`default_nettype wire

// [core/hlt_timer.sv]
// Function
// RULE1: Four-bit clock select chooses one of thirteen counting clocks; codes 1101-1111 none.
// RULE2: Enable low holds every counter and state machine in reset state; here the counter register keeps its value.
// RULE3: Three-bit prescale divides input clock by two to the code, up to 128.
// RULE4: Four-bit postscale divides match events by code plus one.
// RULE5: Hardware clears the enable bit in certain modes.
// RULE6: Prescaler sync bit synchronises prescaler output to the instruction clock.
// RULE7: With prescaler sync on, timer halts during sleep.
// RULE8: Clock edge bit one picks falling edge, zero rising edge.
// RULE9: Software should not change clock edge bit while enabled.
// RULE10: Enable sync bit synchronises enable to timer input clock.
// RULE11: With enable sync, counting starts two input clocks after enabling.
// RULE12: Counting starts on enable, stops on disable, keeping counter value.
// RULE13: Counter equal to period clears counter on next timer clock.
// RULE14: Five-bit mode field selects free-running, limit, one-shot, monostable modes; here only 01000 one-shot acts, other codes run free.
// RULE15: Four-bit reset select chooses the external reset input; 1111 reserved.
// RULE16: A timer's own postscaled output code is reserved for that instance.
// RULE17: Upper bits of clock select and reset select read as zero.
// RULE18: Mode 01000 one-shot: period match resets counter and clears enable.
// RULE19: Without prescaler sync, timer runs in sleep while clock runs.
// RULE20: Counter advances per prescaled clock; matches feed postscaler producing output event.
// RULE21: Counter and period registers are eight-bit and software read/write.
`default_nettype none
module hlt_timer
    import hlt_pkg::*;
#(
    parameter int INSTANCE = 1
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        instr_clk_tick,
    input  wire logic        clock_pin_input,
    input  wire logic        fast_internal_osc,
    input  wire logic        slow_internal_osc,
    input  wire logic        mid_internal_osc,
    input  wire logic        mid_osc_div16,
    input  wire logic        secondary_osc,
    input  wire logic        zero_cross_out,
    input  wire logic [3:0]  logic_cell_out,
    input  wire logic [14:0] ext_reset_inputs,
    output logic             postscaled_out,
    output logic             ext_reset_level,
    output logic             count_running
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [3:0] clock_select_reg;
    logic [7:0] control_reg;
    logic [7:0] hw_limit_reg;
    logic [3:0] ext_reset_reg;
    logic [7:0] count_value_reg;
    logic [7:0] period_value_reg;
    logic       sleep_reg;
    logic       ack_reg;

    logic       on_bit;
    logic [2:0] prescale_sel;
    logic [3:0] postscale_sel;
    logic       prescaler_sync_en;
    logic       clock_edge_sel;
    logic       enable_sync_en;
    logic [4:0] mode_sel;
    assign on_bit            = control_reg[HLT_ON_BIT];
    assign prescale_sel      = control_reg[6:4];
    assign postscale_sel     = control_reg[3:0];
    assign prescaler_sync_en = hw_limit_reg[HLT_PRESCALER_SYNC_EN_BIT];
    assign clock_edge_sel    = hw_limit_reg[HLT_EDGE_BIT];
    assign enable_sync_en    = hw_limit_reg[HLT_ESYNC_BIT];
    assign mode_sel          = hw_limit_reg[4:0];

    // ************************************************************
    // Clock source selection and synchroniser
    // ************************************************************
    logic src_sel;
    always_comb begin
        unique case (clock_select_reg) // see RULE1
            4'h0:    src_sel = clock_pin_input;
            4'h1:    src_sel = instr_clk_tick;
            4'h2:    src_sel = 1'b0;
            4'h3:    src_sel = fast_internal_osc;
            4'h4:    src_sel = slow_internal_osc;
            4'h5:    src_sel = mid_internal_osc;
            4'h6:    src_sel = mid_osc_div16;
            4'h7:    src_sel = secondary_osc;
            4'h8:    src_sel = zero_cross_out;
            4'h9:    src_sel = logic_cell_out[0];
            4'ha:    src_sel = logic_cell_out[1];
            4'hb:    src_sel = logic_cell_out[2];
            4'hc:    src_sel = logic_cell_out[3];
            default: src_sel = 1'b0;
        endcase
    end

    logic [2:0] src_sync_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_sync_reg <= 3'h0;
        end else if (clk_en) begin
            src_sync_reg <= {src_sync_reg[1:0], src_sel};
        end
    end

    // The system clock itself gives an active edge every cycle
    logic sys_clk_src;
    logic in_edge;
    assign sys_clk_src = (clock_select_reg == 4'h2); // see RULE1
    assign in_edge = sys_clk_src    ? 1'b1
                   : clock_edge_sel ? (src_sync_reg[2] & ~src_sync_reg[1])  // see RULE8
                                    : (~src_sync_reg[2] & src_sync_reg[1]);

    // ************************************************************
    // Reset source selection and synchroniser
    // ************************************************************
    logic rst_src;
    logic own_code;
    assign own_code = (INSTANCE == 1) ? (ext_reset_reg == HLT_RS_FIRST_POST)
                                      : (ext_reset_reg == HLT_RS_SECOND_POST);
    assign rst_src = (own_code || ext_reset_reg > HLT_RS_LAST_VALID) ? 1'b0 // see RULE16
                                                                     : ext_reset_inputs[ext_reset_reg]; // see RULE15
    logic [1:0] rst_sync_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync_reg    <= 2'h0;
            ext_reset_level <= 1'b0;
        end else if (clk_en) begin
            rst_sync_reg    <= {rst_sync_reg[0], rst_src};
            ext_reset_level <= rst_sync_reg[1];
        end
    end

    // ************************************************************
    // Enable path and prescaler
    // ************************************************************
    logic [1:0] en_dly_reg;
    logic       run;
    logic       sleep_block;
    assign sleep_block = prescaler_sync_en & sleep_reg; // see RULE7 RULE19
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_dly_reg <= 2'h0;
        end else if (clk_en) begin
            if (!on_bit) begin
                en_dly_reg <= 2'h0;
            end else if (in_edge) begin
                en_dly_reg <= {en_dly_reg[0], 1'b1}; // see RULE10 RULE11
            end
        end
    end
    assign run = on_bit & (enable_sync_en ? en_dly_reg[HLT_ENABLE_DELAY-1] : 1'b1) & ~sleep_block;

    logic [6:0] pre_cnt_reg;
    logic       pre_tick;
    logic       pre_pending_reg;
    logic       tick;
    assign pre_tick = run & in_edge & (pre_cnt_reg == ((7'h1 << prescale_sel) - 7'h1)); // see RULE3
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_reg <= 7'h0;
        end else if (clk_en) begin
            if (!on_bit) begin
                pre_cnt_reg <= 7'h0; // see RULE2
            end else if (run && in_edge) begin
                pre_cnt_reg <= pre_tick ? 7'h0 : pre_cnt_reg + 7'h1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_pending_reg <= 1'b0;
        end else if (clk_en) begin
            // Prescaler output waits here for the next instruction clock
            if (!on_bit) begin
                pre_pending_reg <= 1'b0;
            end else if (pre_tick) begin
                pre_pending_reg <= 1'b1;
            end else if (instr_clk_tick) begin
                pre_pending_reg <= 1'b0;
            end
        end
    end
    assign tick = prescaler_sync_en ? (pre_pending_reg & instr_clk_tick & run) // see RULE6
                                    : pre_tick;

    // ************************************************************
    // Register bus
    // ************************************************************
    logic wr_hit;
    logic rd_hit;
    logic wr_lo;
    assign wr_hit = avs_write & avs_waitrequest & ~ack_reg;
    assign rd_hit = avs_read & avs_waitrequest & ~ack_reg;
    assign wr_lo  = wr_hit & avs_byteenable[0];

    logic match;
    logic one_shot_clear;
    assign match          = tick & (count_value_reg == period_value_reg);
    assign one_shot_clear = match & (mode_sel == HLT_MODE_ONE_SHOT);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if (clk_en) begin
            ack_reg         <= (wr_hit | rd_hit);
            avs_waitrequest <= ~(wr_hit | rd_hit);
            if (rd_hit) begin
                unique case (avs_address)
                    HLT_OFF_CLOCK_SELECT: avs_readdata <= {28'h0, clock_select_reg}; // see RULE17
                    HLT_OFF_CONTROL:      avs_readdata <= {24'h0, control_reg};
                    HLT_OFF_HW_LIMIT:     avs_readdata <= {24'h0, hw_limit_reg}; // see RULE14
                    HLT_OFF_EXT_RESET:    avs_readdata <= {28'h0, ext_reset_reg}; // see RULE17
                    HLT_OFF_COUNT:        avs_readdata <= {24'h0, count_value_reg}; // see RULE21
                    HLT_OFF_PERIOD:       avs_readdata <= {24'h0, period_value_reg};
                    HLT_OFF_SLEEP_CTRL:   avs_readdata <= {31'h0, sleep_reg};
                    default:              avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_select_reg <= HLT_RST_CLOCK_SELECT[3:0];
            hw_limit_reg     <= HLT_RST_HW_LIMIT;
            ext_reset_reg    <= HLT_RST_EXT_RESET[3:0];
            period_value_reg <= HLT_RST_PERIOD;
            sleep_reg        <= 1'b0;
        end else if (clk_en && wr_lo) begin
            unique case (avs_address)
                HLT_OFF_CLOCK_SELECT: clock_select_reg <= avs_writedata[3:0];
                HLT_OFF_HW_LIMIT:     hw_limit_reg     <= avs_writedata[7:0];
                HLT_OFF_EXT_RESET:    ext_reset_reg    <= avs_writedata[3:0];
                HLT_OFF_PERIOD:       period_value_reg <= avs_writedata[7:0]; // see RULE21
                HLT_OFF_SLEEP_CTRL:   sleep_reg        <= avs_writedata[0];
                default:              ;
            endcase
        end
    end

    // Hardware clear of the enable wins over a same-cycle software write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_reg <= HLT_RST_CONTROL;
        end else if (clk_en) begin
            if (wr_lo && avs_address == HLT_OFF_CONTROL) begin
                control_reg <= avs_writedata[7:0];
            end
            if (one_shot_clear) begin
                control_reg[HLT_ON_BIT] <= 1'b0; // see RULE5 RULE18
            end
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_value_reg <= HLT_RST_COUNT;
        end else if (clk_en) begin
            if (wr_lo && avs_address == HLT_OFF_COUNT) begin
                count_value_reg <= avs_writedata[7:0]; // see RULE21
            end else if (match) begin
                count_value_reg <= 8'h00; // see RULE13
            end else if (tick) begin
                count_value_reg <= count_value_reg + 8'h01; // see RULE12 RULE20
            end
        end
    end

    // ************************************************************
    // Postscaler
    // ************************************************************
    logic [3:0] post_cnt_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            post_cnt_reg   <= 4'h0;
            postscaled_out <= 1'b0;
        end else if (clk_en) begin
            postscaled_out <= 1'b0;
            if (!on_bit) begin
                post_cnt_reg <= 4'h0; // see RULE2
            end else if (match) begin
                if (post_cnt_reg >= postscale_sel) begin
                    post_cnt_reg   <= 4'h0;
                    postscaled_out <= 1'b1; // see RULE4 RULE20
                end else begin
                    post_cnt_reg <= post_cnt_reg + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_running <= 1'b0;
        end else if (clk_en) begin
            count_running <= run;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_match_clears_count: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
        clk_en && match && !(wr_lo && avs_address == HLT_OFF_COUNT) |=> count_value_reg == 8'h00)
        else $error("Counter not cleared after period match");

    a_one_shot_off: assert property (@(posedge clk) disable iff (sys_rst) // see RULE18
        clk_en && one_shot_clear |=> !on_bit)
        else $error("One-shot match did not clear enable");

    a_off_holds_count: assert property (@(posedge clk) disable iff (sys_rst) // see RULE12
        clk_en && !on_bit && !(wr_lo && avs_address == HLT_OFF_COUNT) |=> $stable(count_value_reg))
        else $error("Counter moved while disabled");

    a_off_clears_pre: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
        clk_en && !on_bit |=> pre_cnt_reg == 7'h0 && post_cnt_reg == 4'h0)
        else $error("Prescaler or postscaler not held while off");

    a_sleep_stops: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
        prescaler_sync_en && sleep_reg |-> !run)
        else $error("Timer ran in sleep with prescaler sync");

    a_sync_delay: assert property (@(posedge clk) disable iff (sys_rst) // see RULE11
        enable_sync_en && on_bit && en_dly_reg == 2'h0 |-> !run)
        else $error("Timer started before two input clocks");

    a_post_rate: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
        postscaled_out && $past(clk_en) |-> $past(match) && $past(post_cnt_reg) == $past(postscale_sel))
        else $error("Postscaled event at wrong count");

    a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
        $past(rd_hit) && $past(avs_address) == HLT_OFF_EXT_RESET |-> avs_readdata[31:4] == 28'h0)
        else $error("Reset select upper bits not zero");

    a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst) // see RULE21
        clk_en && rd_hit |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer not one cycle");

    a_count_steps: assert property (@(posedge clk) disable iff (sys_rst) // see RULE20
        clk_en && tick && !match && !(wr_lo && avs_address == HLT_OFF_COUNT) |=>
        count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("Counter did not step on a tick");

    a_freeze_state: assert property (@(posedge clk) disable iff (sys_rst) // see RULE20
        !clk_en |=> $stable(count_value_reg) && $stable(control_reg) && $stable(post_cnt_reg))
        else $error("State moved while clock enable low");

    a_reserved_clock: assert property (@(posedge clk) disable iff (sys_rst) // see RULE1
        clock_select_reg > HLT_CS_LAST_VALID && src_sync_reg == 3'h0 |=>
        clock_select_reg <= HLT_CS_LAST_VALID || !in_edge)
        else $error("Reserved clock code gave an edge");

    a_own_reset_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
        clk_en && own_code |=> !rst_sync_reg[0])
        else $error("Own postscaled output used as reset");

    a_prescaler_sync_en_tick: assert property (@(posedge clk) disable iff (sys_rst) // see RULE6
        tick && prescaler_sync_en |-> instr_clk_tick && !sleep_reg)
        else $error("Synchronised tick off the instruction clock");

endmodule : hlt_timer
`default_nettype wire

// [sim/hlt_timer_bench.sv]
`default_nettype none
module hlt_timer_bench
    import hlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and design
    // ****************************************************************
    logic        clk;
    logic        sys_rst;
    logic        clk_en;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        instr_clk_tick;
    logic        src_clk;
    logic [1:0]  div_q;
    logic [14:0] ext_reset_inputs;
    logic        postscaled_out;
    logic        ext_reset_level;
    logic        count_running;
    logic [7:0]  rd_val;
    logic [7:0]  keep_val;
    int          err_total;
    int          tests_run;
    int          d0;
    int          d1;
    int          c;

    hlt_timer #(.INSTANCE(1)) i_hlt_timer (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .instr_clk_tick(instr_clk_tick),
        .clock_pin_input(src_clk), .fast_internal_osc(src_clk), .slow_internal_osc(src_clk),
        .mid_internal_osc(src_clk), .mid_osc_div16(src_clk), .secondary_osc(src_clk),
        .zero_cross_out(src_clk), .logic_cell_out({4{src_clk}}),
        .ext_reset_inputs(ext_reset_inputs), .postscaled_out(postscaled_out),
        .ext_reset_level(ext_reset_level), .count_running(count_running)
    );

    // ****************************************************************
    // Clock and input clock, eight cycles a period
    // ****************************************************************
    always #2 clk = ~clk;

    always @(posedge clk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            src_clk        <= ~src_clk;
            instr_clk_tick <= src_clk;
        end
    end

    // ****************************************************************
    // Bus access and compares
    // ****************************************************************
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd_val = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 100) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
        end
    endtask : bus

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic chk_int(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_int

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 8'h00, 4'h0);
    endtask : rd

    task automatic gap(output int cyc);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (postscaled_out !== 1'b1 && n < 30000);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (postscaled_out !== 1'b1 && cyc < 30000);
    endtask : gap

    task automatic start_delay(output int cyc);
        wr(HLT_OFF_COUNT, 8'h00);
        wr(HLT_OFF_CONTROL, 8'h80);
        cyc = 0;
        while (count_running !== 1'b1 && cyc < 500) begin
            @(posedge clk);
            cyc++;
        end
        wr(HLT_OFF_CONTROL, 8'h00);
    endtask : start_delay

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        #(4 * 80000);
        err_total++;
        end_sim();
    end

    initial begin
        clk = 1'b0; sys_rst = 1'b1; clk_en = 1'b1; div_q = 2'h0; src_clk = 1'b0;
        instr_clk_tick = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; avs_byteenable = 4'h0; ext_reset_inputs = 15'h6aaa;
        err_total = 0; tests_run = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(HLT_OFF_CLOCK_SELECT); chk8(rd_val, 8'h00);
        rd(HLT_OFF_CONTROL); chk8(rd_val, 8'h00);
        rd(HLT_OFF_HW_LIMIT); chk8(rd_val, 8'h00);
        rd(HLT_OFF_EXT_RESET); chk8(rd_val, 8'h00);
        rd(HLT_OFF_COUNT); chk8(rd_val, HLT_RST_COUNT);
        rd(HLT_OFF_PERIOD); chk8(rd_val, HLT_RST_PERIOD);
        wr(5'h1c, 8'h5a);
        rd(5'h1c); chk8(rd_val, 8'h00);
        bus(1'b1, HLT_OFF_PERIOD, 8'h12, 4'h0);
        rd(HLT_OFF_PERIOD); chk8(rd_val, 8'hff);
        wr(HLT_OFF_CLOCK_SELECT, 8'hf5);
        rd(HLT_OFF_CLOCK_SELECT); chk8(rd_val, 8'h05);
        wr(HLT_OFF_EXT_RESET, 8'hf3);
        rd(HLT_OFF_EXT_RESET); chk8(rd_val, 8'h03);
        wr(HLT_OFF_COUNT, 8'ha5);
        rd(HLT_OFF_COUNT); chk8(rd_val, 8'ha5);
        wr(HLT_OFF_PERIOD, 8'h3c);
        rd(HLT_OFF_PERIOD); chk8(rd_val, 8'h3c);
        // Reset source mux, own post code gives zero
        for (c = 0; c < 16; c++) begin
            wr(HLT_OFF_EXT_RESET, 8'(c));
            repeat (8) @(posedge clk);
            chk1(ext_reset_level, (c == 1 || c == 15) ? 1'b0 : ext_reset_inputs[c]);
        end
        // Every clock source code, reserved ones give no count
        for (c = 0; c < 16; c++) begin
            wr(HLT_OFF_CLOCK_SELECT, 8'(c));
            wr(HLT_OFF_PERIOD, 8'hff);
            wr(HLT_OFF_COUNT, 8'h00);
            wr(HLT_OFF_CONTROL, 8'h80);
            repeat (80) @(posedge clk);
            wr(HLT_OFF_CONTROL, 8'h00);
            rd(HLT_OFF_COUNT); chk1(rd_val != 8'h00, c <= 12);
        end
        // Event spacing: prescale, postscale, edge, period match
        wr(HLT_OFF_CLOCK_SELECT, 8'h00);
        for (c = 0; c < 4; c++) begin
            wr(HLT_OFF_PERIOD, 8'h03);
            wr(HLT_OFF_HW_LIMIT, (c == 1) ? 8'h40 : ((c == 3) ? 8'h80 : 8'h00));
            wr(HLT_OFF_COUNT, 8'h00);
            wr(HLT_OFF_CONTROL, {1'b1, 3'((c == 2) ? 7 : c), 4'((c == 3) ? 15 : 2 * c)});
            gap(d0);
            d1 = 32 * (1 << ((c == 2) ? 7 : c)) * (((c == 3) ? 15 : 2 * c) + 1);
            chk_int(d0, d1);
            wr(HLT_OFF_CONTROL, 8'h00);
        end
        rd(HLT_OFF_COUNT);
        keep_val = rd_val;
        repeat (40) @(posedge clk);
        chk1(count_running, 1'b0);
        rd(HLT_OFF_COUNT); chk8(rd_val, keep_val);
        // Enable synchronised to the input clock
        wr(HLT_OFF_PERIOD, 8'hff);
        wr(HLT_OFF_HW_LIMIT, 8'h00);
        start_delay(d0);
        wr(HLT_OFF_HW_LIMIT, 8'h20);
        start_delay(d1);
        chk1(d1 >= d0 + 8 && d1 <= d0 + 17, 1'b1);
        // Sleep with and without prescaler sync
        wr(HLT_OFF_CONTROL, 8'h80);
        wr(HLT_OFF_SLEEP_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        chk1(count_running, 1'b1);
        rd(HLT_OFF_COUNT);
        keep_val = rd_val;
        repeat (80) @(posedge clk);
        rd(HLT_OFF_COUNT); chk1(rd_val !== keep_val, 1'b1);
        wr(HLT_OFF_HW_LIMIT, 8'ha0);
        repeat (40) @(posedge clk);
        chk1(count_running, 1'b0);
        rd(HLT_OFF_COUNT);
        keep_val = rd_val;
        repeat (80) @(posedge clk);
        rd(HLT_OFF_COUNT); chk8(rd_val, keep_val);
        wr(HLT_OFF_SLEEP_CTRL, 8'h00);
        wr(HLT_OFF_CONTROL, 8'h00);
        // One-shot: match clears count and enable
        wr(HLT_OFF_HW_LIMIT, {3'h0, HLT_MODE_ONE_SHOT});
        wr(HLT_OFF_PERIOD, 8'h05);
        wr(HLT_OFF_COUNT, 8'h00);
        wr(HLT_OFF_CONTROL, 8'h80);
        c = 0;
        do begin
            rd(HLT_OFF_CONTROL);
            c++;
        end while (rd_val[7] !== 1'b0 && c < 60);
        chk1(rd_val[7], 1'b0);
        rd(HLT_OFF_COUNT); chk8(rd_val, 8'h00);
        repeat (8) @(posedge clk);
        chk1(count_running, 1'b0);
        // Clock enable low freezes the running counter
        wr(HLT_OFF_HW_LIMIT, 8'h00);
        wr(HLT_OFF_PERIOD, 8'hff);
        wr(HLT_OFF_CONTROL, 8'h80);
        repeat (40) @(posedge clk);
        rd(HLT_OFF_COUNT);
        keep_val = rd_val;
        clk_en <= 1'b0;
        repeat (80) @(posedge clk);
        clk_en <= 1'b1;
        rd(HLT_OFF_COUNT); chk1(rd_val - keep_val <= 8'h01, 1'b1);
        end_sim();
    end
endmodule : hlt_timer_bench
`default_nettype wire
